// ===== common/fram_wr_pkg.sv
// Constants and types for the serial memory write command path.
// Assumes one 100 MHz system clock that oversamples the serial pins.
package fram_wr_pkg;
    localparam logic [7:0]  OPC_WRITE      = 8'h02;
    localparam logic [7:0]  OPC_DDR_WRITE  = 8'hDE;
    localparam logic [7:0]  OPC_MODE_WRITE = 8'hDA;
    localparam logic [7:0]  OPC_DDR_MODE   = 8'hDD;
    localparam logic [7:0]  OPC_TWO_DATA   = 8'hA2;
    localparam logic [7:0]  OPC_TWO_ADDR   = 8'hA1;
    localparam logic [3:0]  MODE_NIBBLE    = 4'hA;
    localparam logic [7:0]  MODE_DDR_BYTE  = 8'hA5;
    localparam int          ADDR_W         = 21;
    localparam logic [1:0]  ADDR_BYTES     = 2'h3;
    localparam logic [20:0] ADDR_MAX       = 21'h1F_FFFF;
    localparam logic [20:0] ADDR_RST       = 21'h00_0000;
    localparam logic [20:0] ADDR_ONE       = 21'h00_0001;
    localparam int          FIFO_W         = 29;
    localparam int          FIFO_D         = 8;
    localparam logic [3:0]  BYTE_BITS      = 4'h8;
    localparam logic [2:0]  LANE_1         = 3'h1;
    localparam logic [2:0]  LANE_2         = 3'h2;
    localparam logic [2:0]  LANE_4         = 3'h4;

    typedef enum logic [2:0] {
        ST_IDLE, ST_OPC, ST_ADDR, ST_MODE, ST_DATA, ST_IGNORE
    } state_type;
endpackage

// ===== src/spi_write_engine.sv
// Write command decoder for a serial RAM slave, plus its byte FIFO.
// Assumes serial clock well below mclk_i/4 (pins are oversampled) and a
// memory port that drains wr_valid_o/wr_ready_i.
// Notes on behaviour
// - Plain write uses lanes of protocol mode
// - Bytes stream to incrementing addresses until deselect
// - Address 1FFFFF wraps to zero, writing continues
// - Writes execute only with enable latch set
// - Enable latch is never cleared by writes
// - Double-rate write samples address, mode and data on both clock edges
// - Double-rate burst wraps and never stops
// - Single-rate mode byte 1010xxxx enters continuous mode
// - Continuous mode skips opcode on next select
// - Non-Axh mode byte leaves continuous mode
// - Double-rate continuous needs mode byte A5
// - Double-rate mode byte not A5 leaves
// - Two-line data write: data two lanes
// - Two-line data write supports continuous mode
// - Two-line address write: address two lanes
// - Its data on two lanes, MSB line1
// - Two-line address write supports continuous mode
// - Address bits 23 to 21 ignored
// - Protected addresses skipped, address still advances
`timescale 1ns/1ps

module byte_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input  wire logic         mclk_i,
    input  wire logic         sys_rst_i,
    // Fill side
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    // Drain side
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0]  wr_q;
    logic [AW:0]  rd_q;
    wire          full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire          empty = (wr_q == rd_q);
    wire          push  = in_valid_i && !full;
    wire          pop   = out_ready_i && !empty;

    assign in_ready_o  = !full;
    assign out_valid_o = !empty;
    assign out_data_o  = mem[rd_q[AW-1:0]];

    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_q + (AW+1)'(push);
            rd_q <= rd_q + (AW+1)'(pop);
        end
    end
endmodule

module spi_write_engine
    import fram_wr_pkg::*;
(
    // Clock and reset
    input  wire logic              mclk_i,
    input  wire logic              sys_rst_i,
    // Serial pins, all inputs for writes
    input  wire logic              sck_i,
    input  wire logic              cs_n_i,
    input  wire logic              data_line_0_i,
    input  wire logic              data_line_1_i,
    input  wire logic              data_line_2_i,
    input  wire logic              data_line_3_i,
    // Configuration and status
    input  wire logic              write_enable_latch_i,
    input  wire logic              two_line_protocol_mode_i,
    input  wire logic              four_line_protocol_mode_i,
    input  wire logic              protect_en_i,
    input  wire logic [ADDR_W-1:0] protect_lo_i,
    input  wire logic [ADDR_W-1:0] protect_hi_i,
    output logic                   continuous_mode_o,
    output logic [2:0]             lane_width_o,
    output logic                   overrun_o,
    // Memory write stream
    output logic                   wr_valid_o,
    input  wire logic              wr_ready_i,
    output logic [ADDR_W-1:0]      wr_addr_o,
    output logic [7:0]             wr_data_o
);
    logic [5:0]        s1_q;
    logic [5:0]        s2_q;
    logic [1:0]        s3_q;
    state_type         st_q;
    state_type         st_d;
    logic [7:0]        cmd_q;
    logic [7:0]        cmd_d;
    logic [7:0]        sh_q;
    logic [3:0]        cnt_q;
    logic [1:0]        abyte_q;
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] addr_d;
    logic              xip_q;
    logic              xip_d;
    logic [7:0]        xcmd_q;
    logic              ovr_q;
    logic [7:0]        sh_d;
    logic              rise_seen_q;

    // Pins pass two flops before anything looks at them
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s1_q <= 6'h01;
            s2_q <= 6'h01;
            s3_q <= 2'h1;
        end else begin
            s1_q <= {data_line_3_i, data_line_2_i, data_line_1_i, data_line_0_i,
                     sck_i, cs_n_i};
            s2_q <= s1_q;
            s3_q <= s2_q[1:0];
        end
    end

    wire cs_hi    = s2_q[0];
    wire cs_fall  = !s2_q[0] && s3_q[0];
    wire sck_rise = s2_q[1] && !s3_q[1];
    wire sck_fall = !s2_q[1] && s3_q[1];
    wire [3:0] dl = s2_q[5:2];

    wire ddr_cmd   = (cmd_q == OPC_DDR_WRITE) || (cmd_q == OPC_DDR_MODE);
    wire has_mode  = (cmd_q == OPC_MODE_WRITE) || (cmd_q == OPC_DDR_MODE) ||
                     (cmd_q == OPC_TWO_DATA) || (cmd_q == OPC_TWO_ADDR);
    wire [2:0] pw  = four_line_protocol_mode_i ? LANE_4 :
                     two_line_protocol_mode_i  ? LANE_2 : LANE_1;
    wire in_body   = (st_q == ST_ADDR) || (st_q == ST_MODE) || (st_q == ST_DATA);
    // Falling edges count only for double-rate bodies; mode 0 keeps the first
    // falling edge after select inside the frame
    wire sample    = sck_rise || (sck_fall && ddr_cmd && in_body && rise_seen_q);

    // Trailing fall of the last opcode bit is not data: a fall counts only
    // once the body has had its own rise
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rise_seen_q <= 1'b0;
        end else if (cs_hi || cs_fall) begin
            rise_seen_q <= 1'b0;
        end else if (sck_rise && in_body) begin
            rise_seen_q <= 1'b1;
        end
    end

    // Lane width per phase; outside a body the lanes fall back to opcode roles
    wire two_addr  = (cmd_q == OPC_TWO_ADDR) && in_body;
    wire two_data  = (cmd_q == OPC_TWO_DATA) && (st_q == ST_DATA);
    assign lane_width_o = (two_addr || two_data) ? LANE_2 : pw;

    always_comb begin
        sh_d = sh_q;
        if (lane_width_o == LANE_4) begin
            sh_d = {sh_q[3:0], dl[3], dl[2], dl[1], dl[0]};
        end else if (lane_width_o == LANE_2) begin
            sh_d = {sh_q[5:0], dl[1], dl[0]};
        end else begin
            sh_d = {sh_q[6:0], dl[0]};
        end
    end

    wire [3:0] cnt_n     = cnt_q + {1'b0, lane_width_o};
    wire       active    = (st_q != ST_IDLE) && (st_q != ST_IGNORE);
    wire       byte_done = sample && active && (cnt_n == BYTE_BITS);

    wire known_op = (sh_d == OPC_WRITE) || (sh_d == OPC_DDR_WRITE) ||
                    (sh_d == OPC_MODE_WRITE) || (sh_d == OPC_DDR_MODE) ||
                    (sh_d == OPC_TWO_DATA) || (sh_d == OPC_TWO_ADDR);
    wire mode_hit = (cmd_q == OPC_DDR_MODE) ? (sh_d == MODE_DDR_BYTE)
                                            : (sh_d[7:4] == MODE_NIBBLE);
    wire prot     = protect_en_i && (addr_q >= protect_lo_i) && (addr_q <= protect_hi_i);
    wire data_byte = byte_done && (st_q == ST_DATA);
    wire fifo_ready;
    wire push     = data_byte && !prot;

    always_comb begin
        st_d   = st_q;
        cmd_d  = cmd_q;
        addr_d = addr_q;
        xip_d  = xip_q;
        if (cs_hi) begin
            st_d = ST_IDLE;
        end else if (cs_fall) begin
            st_d  = xip_q ? ST_ADDR : ST_OPC;
            cmd_d = xcmd_q;
            // Latch clear: continuous frame ignored, mode kept
            if (xip_q && !write_enable_latch_i) begin
                st_d = ST_IGNORE;
            end
        end else if (byte_done) begin
            case (st_q)
                ST_OPC: begin
                    cmd_d = sh_d;
                    // Latch only read, never cleared here
                    st_d = (known_op && write_enable_latch_i) ? ST_ADDR : ST_IGNORE;
                end
                ST_ADDR: begin
                    // Upper three bits fall off the 21-bit counter
                    addr_d = {addr_q[12:0], sh_d};
                    if (abyte_q == ADDR_BYTES - 2'h1) begin
                        st_d = has_mode ? ST_MODE : ST_DATA;
                    end
                end
                ST_MODE: begin
                    xip_d = mode_hit;
                    st_d  = ST_DATA;
                end
                ST_DATA: begin
                    // Natural 21-bit overflow gives the wrap to zero
                    addr_d = addr_q + ADDR_ONE;
                end
                default: begin
                    st_d = st_q;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q    <= ST_IDLE;
            cmd_q   <= OPC_WRITE;
            addr_q  <= ADDR_RST;
            xip_q   <= 1'b0;
            xcmd_q  <= OPC_WRITE;
            ovr_q   <= 1'b0;
        end else begin
            st_q   <= st_d;
            cmd_q  <= cmd_d;
            addr_q <= addr_d;
            xip_q  <= xip_d;
            if (st_q == ST_MODE && byte_done) begin
                xcmd_q <= cmd_q;
            end
            ovr_q  <= push && !fifo_ready;
        end
    end

    // Bit and address-byte counters restart on every frame
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sh_q    <= 8'h00;
            cnt_q   <= 4'h0;
            abyte_q <= 2'h0;
        end else if (cs_hi || cs_fall || (byte_done && st_q != ST_ADDR)) begin
            sh_q    <= sh_d;
            cnt_q   <= 4'h0;
            abyte_q <= 2'h0;
        end else if (sample && active) begin
            sh_q    <= sh_d;
            cnt_q   <= byte_done ? 4'h0 : cnt_n;
            abyte_q <= abyte_q + 2'(byte_done);
        end
    end

    assign continuous_mode_o = xip_q;
    // The link cannot stall, so a full FIFO loses the byte and says so
    assign overrun_o         = ovr_q;

    byte_fifo #(
        .W (FIFO_W),
        .D (FIFO_D)
    ) u_fifo (
        .mclk_i      (mclk_i),
        .sys_rst_i   (sys_rst_i),
        .in_valid_i  (push),
        .in_ready_o  (fifo_ready),
        .in_data_i   ({addr_q, sh_d}),
        .out_valid_o (wr_valid_o),
        .out_ready_i (wr_ready_i),
        .out_data_o  ({wr_addr_o, wr_data_o})
    );

    property p_wrap;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (data_byte && addr_q == ADDR_MAX && !cs_hi) |=> (addr_q == ADDR_RST);
    endproperty
    a_wrap: assert property (p_wrap) else $error("address did not wrap");

    property p_incr;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (data_byte && !cs_hi) |=> (addr_q == $past(addr_q) + ADDR_ONE);
    endproperty
    a_incr: assert property (p_incr) else $error("address did not advance");

    property p_wel;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (st_q == ST_OPC && byte_done && !cs_hi && !write_enable_latch_i)
            |=> (st_q == ST_IGNORE) [*2];
    endproperty
    a_wel: assert property (p_wel) else $error("write ran with latch clear");

    property p_xip_in;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (st_q == ST_MODE && byte_done && !cs_hi && cmd_q != OPC_DDR_MODE
            && sh_d[7:4] == MODE_NIBBLE) |=> xip_q;
    endproperty
    a_xip_in: assert property (p_xip_in) else $error("Axh did not enter");

    property p_xip_out;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (st_q == ST_MODE && byte_done && !cs_hi && !mode_hit) |=> !xip_q;
    endproperty
    a_xip_out: assert property (p_xip_out) else $error("mode not left");

    property p_ddr_a5;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (st_q == ST_MODE && byte_done && !cs_hi && cmd_q == OPC_DDR_MODE)
            |=> (xip_q == ($past(sh_d) == MODE_DDR_BYTE));
    endproperty
    a_ddr_a5: assert property (p_ddr_a5) else $error("A5 check wrong");

    property p_skip;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (cs_fall && xip_q && write_enable_latch_i) |=> (st_q == ST_ADDR);
    endproperty
    a_skip: assert property (p_skip) else $error("opcode not skipped");

    property p_prot;
        @(posedge mclk_i) disable iff (sys_rst_i)
        data_byte && prot |=> !wr_valid_o || $stable(wr_valid_o) || !$past(fifo_ready);
    endproperty
    a_prot: assert property (p_prot) else $error("protected byte stored");

    property p_lane;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (st_q == ST_DATA && (cmd_q == OPC_TWO_DATA || cmd_q == OPC_TWO_ADDR))
            |-> (lane_width_o == LANE_2);
    endproperty
    a_lane: assert property (p_lane) else $error("two-line width wrong");

    property p_idle;
        @(posedge mclk_i) disable iff (sys_rst_i)
        cs_hi |=> (st_q == ST_IDLE);
    endproperty
    a_idle: assert property (p_idle) else $error("frame not ended");

    c_push: cover property (@(posedge mclk_i) disable iff (sys_rst_i) push);
    c_wrap: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
        data_byte && addr_q == ADDR_MAX);
    c_skip: cover property (@(posedge mclk_i) disable iff (sys_rst_i) cs_fall && xip_q);
    c_ddr:  cover property (@(posedge mclk_i) disable iff (sys_rst_i)
        sck_fall && ddr_cmd && st_q == ST_DATA);
endmodule

// ===== tb/spi_host_model.sv
// Host side model: select, serial clock and four data lanes, mode 0.
// Assumes a free-running mclk_i; each clock level is held 8 cycles.
`timescale 1ns/1ps
module spi_host_model (
    // Timing reference
    input  wire logic  mclk_i,
    // Serial pins
    output logic       sck_o,
    output logic       cs_n_o,
    output logic [3:0] lane_o
);
    initial begin
        sck_o  = 1'b0;  // Idles low between frames
        cs_n_o = 1'b1;
        lane_o = 4'h0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    // Data held 4 cycles each side, outlasting the pin synchronisers
    task automatic edge_out(input logic [3:0] v);
        lane_o <= v;
        tick(4);
        sck_o <= ~sck_o;
        tick(4);
    endtask
    // MSB first, upper lane carries the earlier bit
    task automatic send(input logic [7:0] b, input int w, input logic ddr);
        logic [7:0] sh;
        for (int i = 0; i < 8 / w; i++) begin
            sh = b << (i * w);
            edge_out(4'(sh >> (8 - w)));
            if (!ddr) begin
                edge_out(4'(sh >> (8 - w)));
            end
        end
    endtask
    task automatic frame(input logic oe, input logic [7:0] op, input int ow,
                         input logic [23:0] a, input int aw, input logic me,
                         input logic [7:0] md, input int dw, input logic ddr,
                         input int n, input logic [7:0] d [16]);
        cs_n_o <= 1'b0;
        tick(4);
        if (oe) begin
            send(op, ow, 1'b0);  // Omitted in continuous frames
        end
        for (int k = 2; k >= 0; k--) begin
            send(a[8*k +: 8], aw, ddr);
        end
        if (me) begin
            send(md, aw, ddr);
        end
        for (int k = 0; k < n; k++) begin
            send(d[k], dw, ddr);
        end
        tick(4);
        cs_n_o <= 1'b1;
        lane_o <= ~lane_o;  // Released lanes must not echo the last bit
        tick(12);
    endtask
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the write command path and its FIFO.
// Assumes spi_host_model as far side; the memory port is driven here.
`timescale 1ns/1ps
module testbench;
    import fram_wr_pkg::*;
    logic              mclk_i    = 1'b0;
    logic              sys_rst_i = 1'b1;
    logic              sck;
    logic              cs_n;
    logic [3:0]        lane;
    logic              write_enable_latch = 1'b1, pm2 = 1'b0, pm4 = 1'b0, pen = 1'b0;
    logic [ADDR_W-1:0] plo = 21'h00_0010;
    logic [ADDR_W-1:0] phi = 21'h00_0011;
    logic              cont, ovr, wv, rdy = 1'b0, stall = 1'b0;
    logic [2:0]        lw;
    logic [ADDR_W-1:0] wa;
    logic [7:0]        wd;
    logic [7:0]        d [16];
    logic [28:0]       exp_q [$];
    int                seed = 72, mismatches = 0, cmp_count = 0, ovr_cnt = 0, base;

    initial begin
        forever #5 mclk_i = ~mclk_i;
    end
    spi_host_model u_spi_host_model (.mclk_i(mclk_i), .sck_o(sck), .cs_n_o(cs_n), .lane_o(lane));
    spi_write_engine u_spi_write_engine (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .sck_i(sck), .cs_n_i(cs_n),
        .data_line_0_i(lane[0]), .data_line_1_i(lane[1]), .data_line_2_i(lane[2]),
        .data_line_3_i(lane[3]), .write_enable_latch_i(write_enable_latch), .two_line_protocol_mode_i(pm2),
        .four_line_protocol_mode_i(pm4), .protect_en_i(pen), .protect_lo_i(plo),
        .protect_hi_i(phi), .continuous_mode_o(cont), .lane_width_o(lw), .overrun_o(ovr),
        .wr_valid_o(wv), .wr_ready_i(rdy), .wr_addr_o(wa), .wr_data_o(wd));

    task automatic check(input string what, input logic [28:0] e, input logic [28:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("unexpected %s: expected %h seen %h", what, e, g);
            mismatches++;
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Memory port: random stalls, each accepted entry against the oldest note
    always @(posedge mclk_i) begin
        rdy <= !stall && ($random(seed) % 4 != 0);
        if (ovr === 1'b1) begin
            ovr_cnt++;
        end
        if (sys_rst_i === 1'b0 && wv === 1'b1 && rdy) begin
            if (exp_q.size() == 0) begin
                check("stray write", 29'h0, {wa, wd});
            end else begin
                check("write entry", exp_q.pop_front(), {wa, wd});
            end
        end
    end
    task automatic run(input logic oe, input logic [7:0] op, input int ow, input logic [23:0] a,
                       input int aw, input logic me, input logic [7:0] md, input int dw,
                       input logic ddr, input int n, input int lim);
        logic [ADDR_W-1:0] ad;
        @(posedge mclk_i);
        for (int k = 0; k < n; k++) begin
            d[k] = 8'($random(seed));
            ad = a[ADDR_W-1:0] + ADDR_W'(k);
            if (k < lim && !(pen && ad >= plo && ad <= phi)) begin
                exp_q.push_back({ad, d[k]});
            end
        end
        u_spi_host_model.frame(oe, op, ow, a, aw, me, md, dw, ddr, n, d);
    endtask
    task automatic drain(input string name);
        int t = 0;
        while (exp_q.size() != 0 && t < 4000) begin
            @(posedge mclk_i);
            t++;
        end
        if (t >= 4000) begin
            $display("unexpected %s drain: expected 0 seen %0d", name, exp_q.size());
            mismatches++;
            final_report();
        end
        repeat (4) @(posedge mclk_i);
        check("fifo empty", 29'h0, 29'(wv));
        $display("test %s done", name);
    endtask

    initial begin
        repeat (3) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        check("lane width", 29'(LANE_1), 29'(lw));
        run(1, OPC_WRITE, 1, 24'hFF_FFFF, 1, 0, 8'h00, 1, 0, 3, 3);
        drain("plain wrap");
        pm2 <= 1'b1;
        run(1, OPC_WRITE, 2, 24'h00_0100, 2, 0, 8'h00, 2, 0, 2, 2);
        pm4 <= 1'b1;
        run(1, OPC_WRITE, 4, 24'h00_0200, 4, 0, 8'h00, 4, 0, 2, 2);
        run(1, OPC_DDR_WRITE, 4, 24'h1F_FFFE, 4, 0, 8'h00, 4, 1, 4, 4);
        check("lane width", 29'(LANE_4), 29'(lw));
        run(1, OPC_DDR_MODE, 4, 24'h00_0300, 4, 1, MODE_DDR_BYTE, 4, 1, 2, 2);
        check("continuous", 29'h1, 29'(cont));
        run(0, 8'h00, 4, 24'h00_0310, 4, 1, 8'hA4, 4, 1, 2, 2);
        check("continuous", 29'h0, 29'(cont));
        drain("quad and ddr");
        pm2 <= 1'b0;
        pm4 <= 1'b0;
        write_enable_latch <= 1'b0;
        run(1, OPC_WRITE, 1, 24'h00_0400, 1, 0, 8'h00, 1, 0, 2, 0);
        write_enable_latch <= 1'b1;
        run(1, 8'h03, 1, 24'h00_0400, 1, 0, 8'h00, 1, 0, 2, 0);
        run(1, OPC_WRITE, 1, 24'h00_0410, 1, 0, 8'h00, 1, 0, 2, 2);
        drain("enable latch");
        run(1, OPC_MODE_WRITE, 1, 24'h00_0500, 1, 1, 8'hA3, 1, 0, 1, 1);
        check("continuous", 29'h1, 29'(cont));
        run(0, 8'h00, 1, 24'h00_0510, 1, 1, 8'hA7, 1, 0, 2, 2);
        write_enable_latch <= 1'b0;
        run(0, 8'h00, 1, 24'h00_0520, 1, 1, 8'h5C, 1, 0, 2, 0);
        check("continuous", 29'h1, 29'(cont));
        write_enable_latch <= 1'b1;
        run(0, 8'h00, 1, 24'h00_0530, 1, 1, 8'h5C, 1, 0, 2, 2);
        check("continuous", 29'h0, 29'(cont));
        drain("mode byte");
        run(1, OPC_TWO_DATA, 1, 24'h00_0600, 1, 1, 8'hAF, 2, 0, 2, 2);
        check("continuous", 29'h1, 29'(cont));
        run(0, 8'h00, 1, 24'h00_0610, 1, 1, 8'h00, 2, 0, 2, 2);
        check("continuous", 29'h0, 29'(cont));
        run(1, OPC_TWO_ADDR, 1, 24'hE0_0700, 2, 1, 8'hA0, 2, 0, 2, 2);
        check("continuous", 29'h1, 29'(cont));
        run(0, 8'h00, 1, 24'h00_0710, 2, 1, 8'hFF, 2, 0, 2, 2);
        check("continuous", 29'h0, 29'(cont));
        drain("two line");
        pen <= 1'b1;
        run(1, OPC_WRITE, 1, 24'h00_000F, 1, 0, 8'h00, 1, 0, 4, 4);
        drain("protected range");
        pen <= 1'b0;
        stall <= 1'b1;
        base = ovr_cnt;
        run(1, OPC_WRITE, 1, 24'h00_0800, 1, 0, 8'h00, 1, 0, 10, FIFO_D);
        check("overrun count", 29'h2, 29'(ovr_cnt - base));
        stall <= 1'b0;
        drain("fifo full");
        final_report();
    end
endmodule
